// ==== inc/bus_ctrl_defs.vh ====
/*
 * Constants for the backplane bus control block: status bit positions,
 * timing figures and derived cycle counts.
 * Assumes a 50 MHz system clock.
 */
`ifndef BUS_CTRL_DEFS_VH
`define BUS_CTRL_DEFS_VH

// ***********************************
// clock and timing
// ***********************************
`define CLK_PERIOD_NS      20
`define WAIT_STATE_NS      500
`define WAIT_STATE_CYCLES  (`WAIT_STATE_NS / `CLK_PERIOD_NS)
`define PHASE_HALF_CYCLES  2

// ***********************************
// status word bit positions
// ***********************************
`define ST_FETCH   0
`define ST_OUT     1
`define ST_INP     2
`define ST_MEMR    3
`define ST_HLTA    4
`define ST_INTA    5
`define ST_WO      6
`define ST_STACK   7
`define ST_WIDTH   8

// ***********************************
// cycle kinds on cycle_kind_i
// ***********************************
`define KIND_FETCH  3'h0
`define KIND_MEMRD  3'h1
`define KIND_MEMWR  3'h2
`define KIND_STKRD  3'h3
`define KIND_STKWR  3'h4
`define KIND_INP    3'h5
`define KIND_OUT    3'h6
`define KIND_INTA   3'h7

`define RESET_IR    8'h00
`define RESET_PC    16'h0000

`endif

// ==== src/bus_fifo.v ====
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes a single clock and an active-low synchronous-domain reset.
 */
`include "bus_ctrl_defs.vh"

module bus_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clock_i,
	input  wire             rst_n_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end

	// storage holds no reset: contents only count when flagged valid
	always @(posedge clock_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule

// ==== src/panel_gate.v ====
/*
 * Front-panel takeover of the data-input path and the ready line.
 * Assumes the panel request levels are synchronous to clock_i.
 */
`include "bus_ctrl_defs.vh"

module panel_gate (
	input  wire       clock_i,
	input  wire       rst_n_i,
	input  wire       sense_switch_read_req_i,
	input  wire       panel_stop_i,
	input  wire       panel_run_i,
	input  wire       panel_ready_override_i,
	input  wire       panel_ready_i,
	input  wire       processor_ready_in_i,
	input  wire [7:0] sense_switches_i,
	input  wire [7:0] bus_data_in_i,
	output reg        data_input_gate_o,
	output reg        run_o,
	output wire       ready_o,
	output wire [7:0] data_in_o
);
	reg stopped;

	// RL14 stop/run flip-flop
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			stopped <= 1'b0;
		else if (panel_stop_i)
			stopped <= 1'b1;
		else if (panel_run_i)
			stopped <= 1'b0;
	end

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_input_gate_o <= 1'b1;
			run_o             <= 1'b0;
		end
		else
		begin
			// RL8 sense read takes the gate
			data_input_gate_o <= ~sense_switch_read_req_i;
			// RL14 run while reset
			run_o <= ~stopped;
		end
	end

	// RL10 gate high selects processor drivers
	assign data_in_o = data_input_gate_o ? bus_data_in_i : sense_switches_i;
	// RL11 panel owns ready while the override is set
	assign ready_o = panel_ready_override_i ? panel_ready_i : processor_ready_in_i;
endmodule

// ==== src/bus_ctrl.v ====
/*
 * Processor-board bus control: machine-cycle sequencer producing status,
 * command strobes, hold/wait/interrupt handling and front-panel takeover.
 * Assumes cycle requests come from a core through a 16-word FIFO, and
 * that every input is synchronous to clock_i.
 */
// Functional notes
// RL1: fetch status on first opcode byte
// RL2: output status; data valid during write strobe
// RL3: input status; device drives during data-in
// RL4: memory-read status; halt acknowledge after halt
// RL5: write-op status; stack status on stack address
// RL6: interrupt acknowledge status on acknowledge cycle
// RL7: bus clock is inverted phase two
// RL8: sense read enables panel drivers
// RL9: status strobe loads status latch early
// RL10: data gate selects processor or panel drivers
// RL11: panel ready override controls ready
// RL12: memory board stores on write strobe
// RL13: memory boards hold and report protect
// RL14: run indication while stop flip-flop reset
// RL15: boards pull ready to stretch cycles
// RL16: interrupt sampled at end or halt
// RL17: external hold; buses released after cycle
// RL18: reset clears counter and instruction register
// RL19: sync pulse starts every machine cycle
// RL20: write strobe with stable data
// RL21: data-bus-in output while bus inputs
// RL22: I/O devices clear on external clear
// RL23: hold acknowledge and float after cycle
// RL24: wait output and 0.5 us waits
// RL25: interrupt-enable follows flip-flop via EI/DI
`include "bus_ctrl_defs.vh"

module bus_ctrl #(
	parameter WAIT_CYCLES = `WAIT_STATE_CYCLES,
	parameter FIFO_DEPTH  = 16
) (
	input  wire        clock_i,
	input  wire        resetn_i,
	input  wire [2:0]  cycle_kind_i,
	input  wire [15:0] cycle_addr_i,
	input  wire [7:0]  cycle_data_i,
	input  wire        cycle_last_i,
	input  wire        cycle_valid_i,
	output wire        cycle_ready_o,
	input  wire        halt_i,
	input  wire        ei_i,
	input  wire        di_i,
	input  wire        irq_request_i,
	input  wire        hold_request_i,
	input  wire        processor_ready_in_i,
	input  wire        sense_switch_read_req_i,
	input  wire        panel_stop_i,
	input  wire        panel_run_i,
	input  wire        panel_ready_override_i,
	input  wire        panel_ready_i,
	input  wire [7:0]  sense_switches_i,
	input  wire [7:0]  data_bus_i,
	output reg  [7:0]  status_o,
	output reg  [15:0] addr_o,
	output reg  [7:0]  data_o,
	output reg         addr_oe_o,
	output reg         data_oe_o,
	output reg         cycle_sync_o,
	output reg         status_latch_strobe_o,
	output reg         write_strobe_o,
	output reg         data_in_strobe_o,
	output reg         hold_ack_o,
	output reg         wait_state_out_o,
	output reg         irq_enabled_out_o,
	output reg         phase2_o,
	output wire        bus_clock_o,
	output wire        data_input_gate_o,
	output wire        run_o,
	output reg  [7:0]  read_data_o,
	output reg         read_valid_o,
	output reg  [15:0] program_counter_o,
	output reg  [7:0]  instr_reg_o
);
	// ***********************************
	// states
	// ***********************************
	localparam S_IDLE = 6'b000001;
	localparam S_T1   = 6'b000010;
	localparam S_T2   = 6'b000100;
	localparam S_WAIT = 6'b001000;
	localparam S_T3   = 6'b010000;
	localparam S_HOLD = 6'b100000;

	// ***********************************
	// reset release
	// ***********************************
	reg rst_meta;
	reg rst_n;
	always @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ***********************************
	// request FIFO
	// ***********************************
	wire [27:0] fifo_out;
	wire        fifo_valid;
	reg         fifo_pop;
	bus_fifo #(
		.WIDTH (28),
		.DEPTH (FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n),
		.in_data_i   ({cycle_last_i, cycle_kind_i, cycle_addr_i, cycle_data_i}),
		.in_valid_i  (cycle_valid_i),
		.in_ready_o  (cycle_ready_o),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

	// ***********************************
	// front panel
	// ***********************************
	wire       ready;
	wire [7:0] din;
	panel_gate u_panel (
		.clock_i                 (clock_i),
		.rst_n_i                 (rst_n),
		.sense_switch_read_req_i (sense_switch_read_req_i),
		.panel_stop_i            (panel_stop_i),
		.panel_run_i             (panel_run_i),
		.panel_ready_override_i  (panel_ready_override_i),
		.panel_ready_i           (panel_ready_i),
		.processor_ready_in_i    (processor_ready_in_i),
		.sense_switches_i        (sense_switches_i),
		.bus_data_in_i           (data_bus_i),
		.data_input_gate_o       (data_input_gate_o),
		.run_o                   (run_o),
		.ready_o                 (ready),
		.data_in_o               (din)
	);

	// ***********************************
	// status decode
	// ***********************************
	function [7:0] status_of;
		input [2:0] kind;
		input       halted;
		input       fetch_first;
		reg   [7:0] s;
		begin
			s = 8'h00;
			case (kind)
				`KIND_FETCH: s[`ST_MEMR] = 1'b1;
				`KIND_MEMRD: s[`ST_MEMR] = 1'b1;
				`KIND_MEMWR: s[`ST_WO] = 1'b1;
				`KIND_STKRD: s = 8'h00 | (8'h01 << `ST_MEMR) | (8'h01 << `ST_STACK);
				`KIND_STKWR: s = (8'h01 << `ST_WO) | (8'h01 << `ST_STACK);
				`KIND_INP:   s[`ST_INP] = 1'b1;
				`KIND_OUT:   s = (8'h01 << `ST_OUT) | (8'h01 << `ST_WO);
				`KIND_INTA:  s = (8'h01 << `ST_INTA) | (8'h01 << `ST_FETCH);
				default:     s = 8'h00;
			endcase
			// RL1 first opcode byte
			if (kind == `KIND_FETCH && fetch_first)
				s[`ST_FETCH] = 1'b1;
			// RL4 halt acknowledge
			if (halted)
				s[`ST_HLTA] = 1'b1;
			status_of = s;
		end
	endfunction

	function is_write;
		input [2:0] kind;
		begin
			is_write = (kind == `KIND_MEMWR) || (kind == `KIND_STKWR) || (kind == `KIND_OUT);
		end
	endfunction

	// ***********************************
	// sequencer
	// ***********************************
	reg [5:0]  state;
	reg [27:0] cur;
	reg        fetch_first;
	reg        halted;
	reg        irq_pending;
	reg [9:0]  wait_cnt;
	reg [1:0]  phase_cnt;
	wire       cur_wr = is_write(cur[26:24]);

	// RL7 bus clock from phase two
	assign bus_clock_o = ~phase2_o;

	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_cnt <= 2'h0;
			phase2_o  <= 1'b0;
		end
		else
		begin
			phase_cnt <= phase_cnt + 2'h1;
			if (phase_cnt == 2'h1)
				phase2_o <= ~phase2_o;
		end
	end

	always @*
	begin
		// a halted core must not lose the head word: pop only when it is taken
		fifo_pop = (state == S_IDLE) && fifo_valid && !hold_request_i && !irq_pending &&
		           !halted;
	end

	always @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state                 <= S_IDLE;
			cur                   <= 28'h0;
			fetch_first           <= 1'b1;
			halted                <= 1'b0;
			irq_pending           <= 1'b0;
			wait_cnt              <= 10'h0;
			status_o              <= 8'h00;
			addr_o                <= 16'h0000;
			data_o                <= 8'h00;
			addr_oe_o             <= 1'b1;
			data_oe_o             <= 1'b0;
			cycle_sync_o          <= 1'b0;
			status_latch_strobe_o <= 1'b0;
			write_strobe_o        <= 1'b0;
			data_in_strobe_o      <= 1'b0;
			hold_ack_o            <= 1'b0;
			wait_state_out_o      <= 1'b0;
			irq_enabled_out_o     <= 1'b0;
			read_data_o           <= 8'h00;
			read_valid_o          <= 1'b0;
			// RL18 reset clears counter and IR
			program_counter_o     <= `RESET_PC;
			instr_reg_o           <= `RESET_IR;
		end
		else
		begin
			cycle_sync_o          <= 1'b0;
			status_latch_strobe_o <= 1'b0;
			read_valid_o          <= 1'b0;
			// RL25 EI sets, DI clears
			if (ei_i)
				irq_enabled_out_o <= 1'b1;
			else if (di_i)
				irq_enabled_out_o <= 1'b0;
			if (halt_i)
				halted <= 1'b1;
			case (state)
				S_IDLE:
				begin
					// RL4 halt acknowledge shown while halted between cycles
					status_o[`ST_HLTA] <= halted;
					// RL16 sample at instruction end or halt, not in hold
					if (irq_request_i && irq_enabled_out_o && !hold_ack_o &&
					    (fetch_first || halted))
						irq_pending <= 1'b1;
					// RL23 float and acknowledge between cycles
					if (hold_request_i)
					begin
						hold_ack_o <= 1'b1;
						addr_oe_o  <= 1'b0;
						data_oe_o  <= 1'b0;
						state      <= S_HOLD;
					end
					else if (irq_pending)
					begin
						// RL6 acknowledge cycle, interrupts then disabled
						cur               <= {1'b1, `KIND_INTA, program_counter_o, 8'h00};
						irq_pending       <= 1'b0;
						halted            <= 1'b0;
						irq_enabled_out_o <= 1'b0;
						state             <= S_T1;
					end
					else if (fifo_valid && !halted)
					begin
						cur   <= fifo_out;
						state <= S_T1;
					end
				end
				S_T1:
				begin
					// RL19 sync at cycle start
					cycle_sync_o          <= 1'b1;
					// RL9 status loaded at the earliest point
					status_latch_strobe_o <= 1'b1;
					status_o  <= status_of(cur[26:24], halted, fetch_first);
					addr_o    <= cur[23:8];
					addr_oe_o <= 1'b1;
					if (cur[26:24] == `KIND_FETCH && fetch_first)
						program_counter_o <= cur[23:8];
					state <= S_T2;
				end
				S_T2:
				begin
					if (cur_wr)
					begin
						// RL20 RL2 data driven in the same cycle the strobe rises
						data_o         <= cur[7:0];
						data_oe_o      <= 1'b1;
						write_strobe_o <= 1'b1;
					end
					else
						// RL21 RL3 bus in input mode
						data_in_strobe_o <= 1'b1;
					wait_cnt <= WAIT_CYCLES[9:0];
					// RL24 RL15 stretch when not ready
					if (!ready)
					begin
						wait_state_out_o <= 1'b1;
						state            <= S_WAIT;
					end
					else
						state <= S_T3;
				end
				S_WAIT:
				begin
					if (wait_cnt > 10'h1)
						wait_cnt <= wait_cnt - 10'h1;
					else if (ready)
					begin
						wait_state_out_o <= 1'b0;
						state            <= S_T3;
					end
					else
						wait_cnt <= WAIT_CYCLES[9:0];
				end
				S_T3:
				begin
					write_strobe_o   <= 1'b0;
					data_in_strobe_o <= 1'b0;
					data_oe_o        <= 1'b0;
					if (!cur_wr)
					begin
						// RL8 RL10 panel may source data
						read_data_o  <= din;
						read_valid_o <= 1'b1;
						if (cur[26:24] == `KIND_FETCH && fetch_first)
							instr_reg_o <= din;
					end
					if (cur[26:24] == `KIND_FETCH || cur[26:24] == `KIND_INTA)
						fetch_first <= 1'b0;
					if (cur[27])
						fetch_first <= 1'b1;
					status_o <= halted ? (8'h01 << `ST_HLTA) : 8'h00;
					state    <= S_IDLE;
				end
				S_HOLD:
				begin
					// RL17 buses stay released while held
					if (!hold_request_i)
					begin
						hold_ack_o <= 1'b0;
						addr_oe_o  <= 1'b1;
						state      <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== testbench/bus_ctrl_properties.sv ====
/* Port-level assertions for bus_ctrl.
   Assumes one clock and an async active-low reset; bound to every bus_ctrl. */
`include "bus_ctrl_defs.vh"
module bus_ctrl_properties (
	input wire       clock_i,
	input wire       resetn_i,
	input wire       ei_i,
	input wire       di_i,
	input wire       sense_switch_read_req_i,
	input wire       panel_stop_i,
	input wire [7:0] status_o,
	input wire [7:0] data_o,
	input wire       addr_oe_o,
	input wire       data_oe_o,
	input wire       cycle_sync_o,
	input wire       status_latch_strobe_o,
	input wire       write_strobe_o,
	input wire       data_in_strobe_o,
	input wire       hold_ack_o,
	input wire       irq_enabled_out_o,
	input wire       phase2_o,
	input wire       bus_clock_o,
	input wire       data_input_gate_o,
	input wire       run_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	property p_bus_clock; bus_clock_o == !phase2_o; endproperty
	a_bus_clock: assert property (p_bus_clock) else $error("bus clock wrong");
	property p_sync; cycle_sync_o |-> status_latch_strobe_o ##1 !cycle_sync_o [*3]; endproperty
	a_sync: assert property (p_sync) else $error("sync pulse wrong");
	property p_wr_status; $rose(write_strobe_o) |-> status_o[`ST_WO]; endproperty
	a_wr_status: assert property (p_wr_status) else $error("write status missing");
	property p_wr_data; write_strobe_o && $past(write_strobe_o) |-> $stable(data_o) && data_oe_o;
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data moved");
	property p_data_in; data_in_strobe_o |-> !data_oe_o && !write_strobe_o; endproperty
	a_data_in: assert property (p_data_in) else $error("bus not in input mode");
	property p_hold; hold_ack_o |-> !addr_oe_o && !data_oe_o; endproperty
	a_hold: assert property (p_hold) else $error("bus driven in hold");
	property p_ei; ei_i |=> irq_enabled_out_o; endproperty
	a_ei: assert property (p_ei) else $error("enable not set");
	property p_di; di_i && !ei_i |=> !irq_enabled_out_o; endproperty
	a_di: assert property (p_di) else $error("enable not cleared");
	property p_gate; sense_switch_read_req_i |=> !data_input_gate_o; endproperty
	a_gate: assert property (p_gate) else $error("gate not handed over");
	property p_run; panel_stop_i |=> ##1 !run_o; endproperty
	a_run: assert property (p_run) else $error("run still shown");
	c_hold: cover property (hold_ack_o);
	c_out: cover property (write_strobe_o && status_o[`ST_OUT]);
	c_inta: cover property (cycle_sync_o && status_o[`ST_INTA]);
endmodule
bind bus_ctrl bus_ctrl_properties i_bus_ctrl_properties (.*);

// ==== testbench/bus_board.sv ====
/* Memory and I/O board model on the far side of bus_ctrl.
   Assumes strobes from the design; slow_i asks it to stall ready. */
module bus_board (
	input  wire logic        clock_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        write_strobe_i,
	input  wire logic        data_in_strobe_i,
	input  wire logic        slow_i,
	input  wire logic        protect_set_i,
	input  wire logic        protect_clear_i,
	input  wire logic        io_clear_i,
	output logic      [7:0]  data_o,
	output logic             ready_o,
	output logic             protect_state_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] last;
	logic       protect_set;
	logic       hit;
	int         busy;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'hA5;
		last = 8'h00;
		protect_set = 1'b0;
		busy = 0;
	end
	assign hit = (addr_i[15:12] == 4'h0);
	always @(posedge clock_i)
	begin
		busy <= (write_strobe_i || data_in_strobe_i) ? busy + 1 : 0;
		if (write_strobe_i)
			mem[addr_i[7:0]] <= data_i;
		// external clear zeroes the last data-in value; memory and protect are kept
		if (io_clear_i)
			last <= 8'h00;
		else if (data_in_strobe_i)
			last <= mem[addr_i[7:0]];
		if (hit && protect_set_i)
			protect_set <= 1'b1;
		else if (hit && protect_clear_i)
			protect_set <= 1'b0;
	end
	// addressed board reports its protect state
	assign protect_state_o = hit && protect_set;
	// ready already low at the T2 sample when slow, so a wait is forced
	assign ready_o = !(slow_i && busy < 5);
	// memory in data-in, otherwise ~last, so the released bus never keeps the last value
	assign data_o = data_in_strobe_i ? mem[addr_i[7:0]] : ~last;
endmodule

// ==== testbench/backplane_bus_control_status_tb_top.sv ====
/* Self-checking bench for bus_ctrl with a board model.
   Assumes WAIT_CYCLES shortened to 2; inputs change 1 ns after the edge. */
`include "bus_ctrl_defs.vh"
module backplane_bus_control_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] k; logic [15:0] a; logic [7:0] d;
		logic l; logic [7:0] st; logic [7:0] rd;} row_t;
	logic        clock_i, resetn_i, cycle_last_i, cycle_valid_i, halt_i, ei_i, di_i;
	logic        irq_request_i, hold_request_i, sense_switch_read_req_i, panel_stop_i;
	logic        panel_run_i, panel_ready_override_i, panel_ready_i, slow;
	logic        protect_set_set, protect_set_clr, io_clr;
	wire         protect_set_state;
	logic [2:0]  cycle_kind_i;
	logic [15:0] cycle_addr_i;
	logic [7:0]  cycle_data_i, sense_switches_i;
	wire  [7:0]  data_bus_i, status_o, data_o, read_data_o, instr_reg_o;
	wire  [15:0] addr_o, program_counter_o;
	wire         processor_ready_in_i, cycle_ready_o, addr_oe_o, data_oe_o, cycle_sync_o;
	wire         status_latch_strobe_o, write_strobe_o, data_in_strobe_o, hold_ack_o;
	wire         wait_state_out_o, irq_enabled_out_o, phase2_o, bus_clock_o;
	wire         data_input_gate_o, run_o, read_valid_o;
	int          errors, check_count;
	row_t rows [8] = '{
		'{`KIND_FETCH, 16'h0100, 8'h00, 1'b0, 8'h09, 8'hA5},
		'{`KIND_STKWR, 16'h0FFE, 8'h3C, 1'b0, 8'hC0, 8'h00},
		'{`KIND_MEMWR, 16'h0020, 8'h5A, 1'b0, 8'h40, 8'h00},
		'{`KIND_OUT, 16'h0007, 8'h77, 1'b0, 8'h42, 8'h00},
		'{`KIND_STKRD, 16'h0FFE, 8'h00, 1'b0, 8'h88, 8'h3C},
		'{`KIND_MEMRD, 16'h0020, 8'h00, 1'b0, 8'h08, 8'h5A},
		'{`KIND_INP, 16'h0005, 8'h00, 1'b1, 8'h04, 8'hA0},
		'{`KIND_FETCH, 16'h0101, 8'h00, 1'b1, 8'h09, 8'hA4}};
	bus_ctrl #(.WAIT_CYCLES(2)) i_bus_ctrl (.*);
	bus_board i_bus_board (.clock_i(clock_i), .addr_i(addr_o), .data_i(data_o),
		.write_strobe_i(write_strobe_o), .data_in_strobe_i(data_in_strobe_o),
		.slow_i(slow), .protect_set_i(protect_set_set), .protect_clear_i(protect_set_clr),
		.io_clear_i(io_clr), .data_o(data_bus_i), .ready_o(processor_ready_in_i),
		.protect_state_o(protect_set_state));
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// w: 0 sync, 1 read done, 2 write strobe
	task automatic wait_on(input int w);
		int n;
		n = 0;
		while (n < 200 && (w == 0 ? cycle_sync_o : w == 1 ? read_valid_o : write_strobe_o) !== 1)
		begin
			step(1);
			n++;
		end
		if (n == 200)
			chk(16'hDEAD, 16'h0000);
	endtask
	task automatic push(input row_t r);
		{cycle_kind_i, cycle_addr_i, cycle_data_i, cycle_last_i} = {r.k, r.a, r.d, r.l};
		cycle_valid_i = 1'b1;
		// ready is settled between edges; the next edge is the accepting one
		while (cycle_ready_o !== 1'b1)
			step(1);
		step(1);
	endtask
	task automatic run_row(input row_t r);
		push(r);
		cycle_valid_i = 1'b0;
		wait_on(0);
		chk(status_o, r.st);
		chk(addr_o, r.a);
		wait_on(r.st[`ST_WO] ? 2 : 1);
		chk(r.st[`ST_WO] ? data_o : read_data_o, r.st[`ST_WO] ? r.d : r.rd);
	endtask
	task automatic end_of_test;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clock_i = 0;
		forever #10 clock_i = ~clock_i;
	end
	initial
	begin
		#200000;
		errors++;
		end_of_test();
	end
	initial
	begin
		{resetn_i, cycle_last_i, cycle_valid_i, halt_i, ei_i, di_i, irq_request_i} = 0;
		{hold_request_i, sense_switch_read_req_i, panel_stop_i, panel_run_i} = 0;
		{panel_ready_override_i, panel_ready_i, slow, cycle_kind_i, cycle_addr_i} = 0;
		{cycle_data_i, errors, check_count} = 0;
		{protect_set_set, protect_set_clr, io_clr} = 3'b000;
		sense_switches_i = 8'h3C;
		step(6);
		chk(status_o, 16'h0000);
		resetn_i = 1'b1;
		step(3);
		chk(bus_clock_o, !phase2_o);
		foreach (rows[i])
			run_row(rows[i]);
		// buffer fills under hold, then drains with the board stalling
		hold_request_i = 1'b1;
		repeat (16) push(rows[5]);
		chk(hold_ack_o, 1);
		chk(addr_oe_o, 0);
		chk(cycle_ready_o, 0);
		cycle_valid_i = 1'b0;
		slow = 1'b1;
		hold_request_i = 1'b0;
		repeat (16)
		begin
			wait_on(1);
			chk(read_data_o, 8'h5A);
			step(1);
		end
		for (int m = 0; m < 2; m++)
		begin
			slow = !m;
			panel_ready_override_i = m;
			panel_ready_i = 1'b0;
			push(rows[5]);
			cycle_valid_i = 1'b0;
			wait_on(0);
			step(3);
			chk(wait_state_out_o, 1);
			panel_ready_i = 1'b1;
			wait_on(1);
			chk(read_data_o, 8'h5A);
		end
		{slow, panel_ready_override_i} = 0;
		sense_switch_read_req_i = 1'b1;
		step(1);
		chk(data_input_gate_o, 0);
		run_row(rows[6] ^ 44'h3C ^ 44'hA0);
		sense_switch_read_req_i = 1'b0;
		step(1);
		chk(data_input_gate_o, 1);
		panel_stop_i = 1'b1;
		step(1);
		panel_stop_i = 1'b0;
		step(1);
		chk(run_o, 0);
		panel_run_i = 1'b1;
		step(1);
		panel_run_i = 1'b0;
		step(1);
		chk(run_o, 1);
		protect_set_set = 1'b1;
		step(1);
		protect_set_set = 1'b0;
		chk(protect_set_state, 1);
		protect_set_clr = 1'b1;
		step(1);
		protect_set_clr = 1'b0;
		chk(protect_set_state, 0);
		io_clr = 1'b1;
		step(1);
		io_clr = 1'b0;
		chk(data_bus_i, 8'hFF);
		ei_i = 1'b1;
		step(1);
		{ei_i, halt_i} = 2'b01;
		chk(irq_enabled_out_o, 1);
		step(1);
		halt_i = 1'b0;
		step(2);
		chk(status_o[`ST_HLTA], 1);
		irq_request_i = 1'b1;
		wait_on(0);
		irq_request_i = 1'b0;
		chk(status_o[`ST_INTA], 1);
		wait_on(1);
		chk(irq_enabled_out_o, 0);
		ei_i = 1'b1;
		step(1);
		{ei_i, di_i} = 2'b01;
		step(1);
		{di_i, irq_request_i} = 2'b01;
		chk(irq_enabled_out_o, 0);
		push(rows[7]);
		cycle_valid_i = 1'b0;
		wait_on(0);
		chk(status_o[`ST_INTA], 0);
		irq_request_i = 1'b0;
		wait_on(1);
		resetn_i = 1'b0;
		step(1);
		chk(program_counter_o, 16'h0000);
		chk(instr_reg_o, 8'h00);
		end_of_test();
	end
endmodule
